// *** pic_cascade_host.sv ***
// Host controller driving a master and up to eight slave interrupt controllers
//
// Summary of operation
// - One master plus at most eight slaves
// - Cascaded end of service sent to master, slave
// - Role pin high master, low slave
// - Every controller gets its own init sequence
// - Separate chip select per controller
// - First init word layout, port bit low
// - Second init word gives vector high byte
// - Master third word flags slave inputs
// - Slave third word: zero top, identity low
// - Codes 20h end, A0h end with rotate
// - Single mode skips third init word
`timescale 1ns/1ps
`include "pic_host_defs.svh"

module pic_cascade_host
  import pic_host_pkg::*;
(
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic CE,
  input wire logic CMD_VALID,
  input wire cmd_s CMD,
  output logic CMD_READY,
  output logic RSP_VALID,
  output logic RSP_ERR,
  output logic [23:0] RSP_DATA,
  output logic [2:0] CAS_CODE,
  output logic INT_PEND,
  output logic [8:0] CS_N,
  output logic RD_N,
  output logic WR_N,
  output logic ACK_N,
  output logic A0,
  output logic [7:0] D_O,
  output logic D_OE,
  input wire logic [7:0] D_I,
  input wire logic [2:0] CAS_I,
  input wire logic INT_I,
  output logic [8:0] ROLE_SEL
);

  state_s state_reg;
  state_s state_next;
  step_s nxt_step;
  step_s cur_step;

  function automatic logic [1:0] last_idx(input cmd_s c);
    case (c.op)
      OP_INIT: last_idx = c.single ? 2'h1 : 2'h2;
      OP_EOI_CASC: last_idx = 2'h1;
      OP_ACK: last_idx = 2'h2;
      default: last_idx = 2'h0;
    endcase
  endfunction : last_idx

  function automatic step_s step_of(input cmd_s c, input logic [1:0] i);
    step_s s;
    s.kind = K_WR;
    s.a0 = `PORT_EVEN;
    s.sel = c.sel;
    s.data = 8'h00;
    case (c.op)
      OP_INIT: begin
        if (i == 2'h0) begin
          s.data = {c.vector[7:5], `INIT_CONTROL_FIRST_MARK, c.interval4, c.single, 1'h0};
        end else if (i == 2'h1) begin
          s.a0 = `PORT_ODD;
          s.data = c.vector[15:8];
        end else begin
          s.a0 = `PORT_ODD;
          if (c.sel == `MASTER_SEL) begin
            s.data = c.cascade_cfg;
          end else begin
            s.data = {`SLAVE_ID_PAD, c.cascade_cfg[2:0]};
          end
        end
      end
      OP_MASK_WR: begin
        s.a0 = `PORT_ODD;
        s.data = c.data;
      end
      OP_MASK_RD: begin
        s.kind = K_RD;
        s.a0 = `PORT_ODD;
      end
      OP_EOI: s.data = `END_SERVICE_COMMAND_EOI;
      OP_EOI_CASC: begin
        s.sel = (i == 2'h0) ? `MASTER_SEL : c.sel;
        s.data = `END_SERVICE_COMMAND_EOI;
      end
      OP_ROT_EOI: s.data = `END_SERVICE_COMMAND_ROT_EOI;
      OP_TARGETED_END_OF_SERVICE: s.data = {`END_SERVICE_COMMAND_TARGETED_END_OF_SERVICE, c.level};
      OP_ROT_TARGETED_END_OF_SERVICE: s.data = {`END_SERVICE_COMMAND_ROT_TARGETED_END_OF_SERVICE, c.level};
      OP_ACK: s.kind = K_ACK;
      default: s.data = 8'h00;
    endcase
    return s;
  endfunction : step_of

  always_comb begin
    cur_step = step_of(state_reg.cmd, state_reg.idx);
    if (state_reg.phase == PH_IDLE) begin
      nxt_step = step_of(CMD, 2'h0);
    end else begin
      nxt_step = step_of(state_reg.cmd, state_reg.idx + 2'h1);
    end
  end

  always_comb begin
    state_next = state_reg;
    state_next.rsp_valid = 1'h0;
    state_next.rsp_err = 1'h0;
    state_next.din_s1 = D_I;
    state_next.din_s2 = state_reg.din_s1;
    state_next.cas_s1 = CAS_I;
    state_next.cas_s2 = state_reg.cas_s1;
    state_next.int_s1 = INT_I;
    state_next.int_s2 = state_reg.int_s1;
    state_next.role = `ROLE_PINS;
    case (state_reg.phase)
      PH_IDLE: begin
        if (CMD_VALID && state_reg.ready) begin
          state_next.cmd = CMD;
          state_next.idx = 2'h0;
          if (CMD.sel > `MAX_SEL && CMD.op != OP_ACK) begin
            state_next.rsp_valid = 1'h1;
            state_next.rsp_err = 1'h1;
          end else begin
            state_next.ready = 1'h0;
            state_next.phase = PH_SETUP;
            state_next.cs_n = '1;
            if (nxt_step.kind != K_ACK) begin
              state_next.cs_n[nxt_step.sel] = 1'h0;
            end
            state_next.a0 = nxt_step.a0;
            state_next.dout = nxt_step.data;
            state_next.doe = (nxt_step.kind == K_WR);
          end
        end
      end
      PH_SETUP: begin
        state_next.phase = PH_PULSE;
        state_next.cnt = 6'(`STROBE_CYC - 1);
        case (cur_step.kind)
          K_WR: state_next.wr_n = 1'h0;
          K_RD: state_next.rd_n = 1'h0;
          default: state_next.ack_n = 1'h0;
        endcase
      end
      PH_PULSE: begin
        if (state_reg.cnt != 6'h00) begin
          state_next.cnt = state_reg.cnt - 6'h01;
        end else begin
          state_next.wr_n = 1'h1;
          state_next.rd_n = 1'h1;
          state_next.ack_n = 1'h1;
          state_next.phase = PH_HOLD;
          if (!state_reg.rd_n || !state_reg.ack_n) begin
            state_next.rsp[state_reg.idx * 8 +: 8] = state_reg.din_s2;
          end
          if (!state_reg.ack_n && state_reg.idx == 2'h1) begin
            state_next.cas_code = state_reg.cas_s2;
          end
          if (!state_reg.ack_n) begin
            state_next.cnt = 6'(`ACK_GAP_CYC - 1);
          end else begin
            state_next.cnt = 6'(`HOLD_CYC - 1);
          end
        end
      end
      PH_HOLD: begin
        if (state_reg.cnt != 6'h00) begin
          state_next.cnt = state_reg.cnt - 6'h01;
        end else begin
          state_next.cs_n = '1;
          state_next.doe = 1'h0;
          state_next.phase = PH_GAP;
          state_next.cnt = 6'(`FLOAT_CYC - 1);
        end
      end
      PH_GAP: begin
        if (state_reg.cnt != 6'h00) begin
          state_next.cnt = state_reg.cnt - 6'h01;
        end else if (state_reg.idx != last_idx(state_reg.cmd)) begin
          state_next.idx = state_reg.idx + 2'h1;
          state_next.phase = PH_SETUP;
          if (nxt_step.kind != K_ACK) begin
            state_next.cs_n[nxt_step.sel] = 1'h0;
          end
          state_next.a0 = nxt_step.a0;
          state_next.dout = nxt_step.data;
          state_next.doe = (nxt_step.kind == K_WR);
        end else begin
          state_next.rsp_valid = 1'h1;
          state_next.ready = 1'h1;
          state_next.phase = PH_IDLE;
        end
      end
      default: begin
        state_next.phase = PH_IDLE;
        state_next.ready = 1'h1;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg <= '0;
      state_reg.phase <= PH_IDLE;
      state_reg.cs_n <= '1;
      state_reg.rd_n <= 1'h1;
      state_reg.wr_n <= 1'h1;
      state_reg.ack_n <= 1'h1;
      state_reg.ready <= 1'h1;
      state_reg.role <= `ROLE_PINS;
    end else if (CE) begin
      state_reg <= state_next;
    end
  end

  assign CMD_READY = state_reg.ready;
  assign RSP_VALID = state_reg.rsp_valid;
  assign RSP_ERR = state_reg.rsp_err;
  assign RSP_DATA = state_reg.rsp;
  assign CAS_CODE = state_reg.cas_code;
  assign INT_PEND = state_reg.int_s2;
  assign CS_N = state_reg.cs_n;
  assign RD_N = state_reg.rd_n;
  assign WR_N = state_reg.wr_n;
  assign ACK_N = state_reg.ack_n;
  assign A0 = state_reg.a0;
  assign D_O = state_reg.dout;
  assign D_OE = state_reg.doe;
  assign ROLE_SEL = state_reg.role;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  a_one_select: assert property ($onehot0(~CS_N))
    else $error("More than one chip select active");
  a_ack_unselected: assert property (!ACK_N |-> &CS_N && !D_OE)
    else $error("Chip select or drive during acknowledge");
  a_ack_three_pulses: assert property (
    RSP_VALID && state_reg.cmd.op == OP_ACK |-> state_reg.idx == 2'h2)
    else $error("Acknowledge sequence not three pulses");
  a_init_own_select: assert property (
    state_reg.cmd.op == OP_INIT && !WR_N |-> !CS_N[state_reg.cmd.sel])
    else $error("Init word sent to wrong controller");
  a_first_word_form: assert property (
    state_reg.cmd.op == OP_INIT && state_reg.idx == 2'h0 && !WR_N
    |-> !A0 && D_O[4:3] == `INIT_CONTROL_FIRST_MARK && !D_O[0] && D_O[1] == state_reg.cmd.single)
    else $error("First init word malformed");
  a_second_word_form: assert property (
    state_reg.cmd.op == OP_INIT && state_reg.idx == 2'h1 && !WR_N
    |-> A0 && D_O == state_reg.cmd.vector[15:8])
    else $error("Second init word malformed");
  a_master_third_word: assert property (
    state_reg.cmd.op == OP_INIT && state_reg.idx == 2'h2 && !WR_N && state_reg.cmd.sel == `MASTER_SEL
    |-> A0 && D_O == state_reg.cmd.cascade_cfg)
    else $error("Master third init word malformed");
  a_slave_third_word: assert property (
    state_reg.cmd.op == OP_INIT && state_reg.idx == 2'h2 && !WR_N && state_reg.cmd.sel != `MASTER_SEL
    |-> A0 && D_O[7:3] == `SLAVE_ID_PAD && D_O[2:0] == state_reg.cmd.cascade_cfg[2:0])
    else $error("Slave third init word malformed");
  a_single_skips_third: assert property (
    RSP_VALID && !RSP_ERR && state_reg.cmd.op == OP_INIT
    |-> state_reg.idx == (state_reg.cmd.single ? 2'h1 : 2'h2))
    else $error("Init length disagrees with single mode");
  a_eoi_both_ends: assert property (
    state_reg.cmd.op == OP_EOI_CASC && $fell(WR_N)
    |-> !CS_N[(state_reg.idx == 2'h0) ? `MASTER_SEL : state_reg.cmd.sel] && D_O == `END_SERVICE_COMMAND_EOI)
    else $error("Cascaded end of service misrouted");
  a_eoi_codes: assert property (
    !WR_N && (state_reg.cmd.op == OP_EOI || state_reg.cmd.op == OP_ROT_EOI)
    |-> !A0 && D_O == ((state_reg.cmd.op == OP_EOI) ? `END_SERVICE_COMMAND_EOI : `END_SERVICE_COMMAND_ROT_EOI))
    else $error("End of service code wrong");
  a_strobe_width: assert property ($fell(WR_N) |-> !WR_N [*8])
    else $error("Write strobe too short");
  a_mask_odd_port: assert property (
    state_reg.cmd.op == OP_MASK_WR && !WR_N
    |-> A0 && D_O == state_reg.cmd.data)
    else $error("Mask write malformed");
  a_targeted_end_code: assert property (
    state_reg.cmd.op == OP_TARGETED_END_OF_SERVICE && !WR_N
    |-> !A0 && D_O[7:3] == `END_SERVICE_COMMAND_TARGETED_END_OF_SERVICE && D_O[2:0] == state_reg.cmd.level)
    else $error("Targeted end of service code wrong");
  a_rotate_end_code: assert property (
    state_reg.cmd.op == OP_ROT_TARGETED_END_OF_SERVICE && !WR_N
    |-> !A0 && D_O[7:3] == `END_SERVICE_COMMAND_ROT_TARGETED_END_OF_SERVICE && D_O[2:0] == state_reg.cmd.level)
    else $error("Rotating targeted end code wrong");
  a_refused_quiet: assert property (
    RSP_ERR |-> &CS_N && WR_N && RD_N && ACK_N && CMD_READY)
    else $error("Refused command reached the pins");

endmodule : pic_cascade_host

// *** pic_cascade_host_tb.sv ***
// Self-checking testbench for the cascaded interrupt controller host
`timescale 1ns/1ps
module pic_cascade_host_tb;
  import pic_host_pkg::*;
  logic CLK, ARST_N, CMD_VALID, CMD_READY, RSP_VALID, RSP_ERR, RD_N, WR_N, ACK_N, A0, INT_I;
  logic CE, INT_PEND, D_OE;
  cmd_s CMD;
  cmd_s c;
  logic [23:0] RSP_DATA;
  logic [2:0] CAS_CODE, CAS_I;
  logic [8:0] CS_N, ROLE_SEL;
  logic [7:0] D_O, D_I;
  logic [3:0] req;
  logic [31:0] seed, r;
  logic [15:0] vec [9];
  logic err_seen;
  int bad_count, n_checks;
  op_e ops [4] = '{OP_EOI, OP_ROT_EOI, OP_TARGETED_END_OF_SERVICE, OP_ROT_TARGETED_END_OF_SERVICE};
  pic_cascade_host dut (.CLK(CLK), .ARST_N(ARST_N), .CE(CE), .CMD_VALID(CMD_VALID), .CMD(CMD),
    .CMD_READY(CMD_READY), .RSP_VALID(RSP_VALID), .RSP_ERR(RSP_ERR), .RSP_DATA(RSP_DATA),
    .CAS_CODE(CAS_CODE), .INT_PEND(INT_PEND), .CS_N(CS_N), .RD_N(RD_N), .WR_N(WR_N), .ACK_N(ACK_N), .A0(A0),
    .D_O(D_O), .D_OE(D_OE), .D_I(D_I), .CAS_I(CAS_I), .INT_I(INT_I), .ROLE_SEL(ROLE_SEL));
  pic_cascade_model m (.CS_N(CS_N), .RD_N(RD_N), .WR_N(WR_N), .ACK_N(ACK_N), .A0(A0), .D_O(D_O),
    .ROLE_SEL(ROLE_SEL), .REQ(req), .D_I(D_I), .CAS_I(CAS_I), .INT_I(INT_I));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [7:0] f_end_service_command(input op_e op, input logic [2:0] lvl);
    case (op)
      OP_ROT_EOI: return 8'hA0;
      OP_TARGETED_END_OF_SERVICE: return {5'h0C, lvl};
      OP_ROT_TARGETED_END_OF_SERVICE: return {5'h1C, lvl};
      default: return 8'h20;
    endcase
  endfunction : f_end_service_command
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  task automatic go(input op_e op, input logic [3:0] sel, input logic [7:0] data, input logic [2:0] lvl);
    int i;
    c.op = op;
    c.sel = sel;
    c.data = data;
    c.level = lvl;
    CMD = c;
    CMD_VALID = 1'b1;
    @(posedge CLK);
    #1 CMD_VALID = 1'b0;
    for (i = 0; i < 1000 && RSP_VALID !== 1'b1; i++) begin
      @(posedge CLK);
      #1;
    end
    err_seen = RSP_ERR;
    if (i == 1000) chk(24'h0, 24'h1);
  endtask : go
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  initial begin
    #500000;
    bad_count++;
    final_report();
  end
  initial begin
    ARST_N = 1'b0;
    CE = 1'b1;
    CMD_VALID = 1'b0;
    c = '0;
    CMD = c;
    req = 4'h0;
    seed = 32'h0000000E;
    bad_count = 0;
    n_checks = 0;
    repeat (20) @(posedge CLK);
    #1 ARST_N = 1'b1;
    chk(CS_N, 9'h1FF);
    chk(ROLE_SEL, 9'h001);
    for (int s = 0; s < 9; s++) begin
      r = rnd();
      vec[s] = r[15:0];
      c.vector = r[15:0];
      c.interval4 = r[16];
      c.single = (s == 8);
      c.cascade_cfg = (s == 0) ? 8'hFF : {r[23:19], 3'(s - 1)};
      go(OP_INIT, 4'(s), 8'h00, 3'h0);
      chk(m.icw[s][0], {r[7:5], 2'b10, r[16], s == 8, 1'b0});
      chk(m.icw[s][1], r[15:8]);
      chk(m.icw[s][2], (s == 0) ? 8'hFF : (s == 8) ? 8'h00 : {5'h00, 3'(s - 1)});
      chk(24'(m.wcnt[s]), (s == 8) ? 24'h2 : 24'h3);
    end
    repeat (4) begin
      r = rnd();
      go(OP_MASK_WR, 4'(r[11:8] % 9), r[7:0], 3'h0);
      go(OP_MASK_RD, 4'(r[11:8] % 9), 8'h00, 3'h0);
      chk(RSP_DATA[7:0], r[7:0]);
    end
    repeat (3) begin
      r = rnd();
      // Controller eight runs single, so no slave holds code seven
      r[2:0] = r[2:0] % 3'h7;
      req = {1'b1, r[2:0]};
      go(OP_ACK, 4'h0, 8'h00, 3'h0);
      chk(RSP_DATA, {vec[r[2:0] + 1][15:8], vec[r[2:0] + 1][7:5], 5'h00, 8'hCD});
      chk(CAS_CODE, r[2:0]);
      chk(CAS_I, 3'h0);
      chk(INT_PEND, 1'b1);
      chk(D_OE, 1'b0);
      go(OP_EOI_CASC, 4'(r[2:0] + 1), 8'h00, 3'h0);
      chk(m.isb[0], 8'h00);
      chk(m.last_cmd[r[2:0] + 1], 8'h20);
      req = 4'h0;
    end
    foreach (ops[k]) begin
      r = rnd();
      go(ops[k], 4'(r[3:0] % 9), 8'h00, r[6:4]);
      chk(m.last_cmd[r[3:0] % 9], f_end_service_command(ops[k], r[6:4]));
    end
    chk(INT_PEND, 1'b0);
    // Clock enable low freezes the controller, command not taken
    CE = 1'b0;
    c.op = OP_MASK_WR;
    c.sel = 4'h0;
    CMD = c;
    CMD_VALID = 1'b1;
    repeat (5) @(posedge CLK);
    #1 chk(CMD_READY, 1'b1);
    chk(CS_N, 9'h1FF);
    CMD_VALID = 1'b0;
    CE = 1'b1;
    repeat (2) @(posedge CLK);
    #1 chk(CS_N, 9'h1FF);
    go(OP_MASK_WR, 4'h9, 8'h3C, 3'h0);
    chk(err_seen, 1'b1);
    chk(CS_N, 9'h1FF);
    final_report();
  end
endmodule : pic_cascade_host_tb

// *** pic_cascade_model.sv ***
// Behavioural model of one master and eight slave interrupt controllers
`timescale 1ns/1ps
module pic_cascade_model (
  input wire logic [8:0] CS_N,
  input wire logic RD_N,
  input wire logic WR_N,
  input wire logic ACK_N,
  input wire logic A0,
  input wire logic [7:0] D_O,
  input wire logic [8:0] ROLE_SEL,
  input wire logic [3:0] REQ,
  output logic [7:0] D_I,
  output logic [2:0] CAS_I,
  output logic INT_I
);
  logic [7:0] icw [9][3];
  logic [7:0] mask [9];
  logic [7:0] last_cmd [9];
  logic [7:0] isb [9];
  int step [9];
  int wcnt [9];
  int ackn;
  int c;
  int s;
  logic in_wr;
  logic in_ack;
  function automatic int chip(input logic [8:0] cs);
    for (int i = 0; i < 9; i++) if (!cs[i]) return i;
    return 0;
  endfunction : chip
  function automatic int slave(input logic [2:0] code);
    for (int i = 1; i < 9; i++) if (!ROLE_SEL[i] && icw[i][2][2:0] == code) return i;
    return 0;
  endfunction : slave
  initial begin
    icw = '{default: '{default: 8'h00}};
    mask = '{default: 8'h00};
    last_cmd = '{default: 8'h00};
    isb = '{default: 8'h00};
    step = '{default: 0};
    wcnt = '{default: 0};
    ackn = 0;
    in_wr = 1'b0;
    in_ack = 1'b0;
    D_I = 8'h5A;
    CAS_I = 3'h0;
  end
  assign INT_I = REQ[3];
  // Words take effect on the trailing edge of the write strobe
  // Rising edges out of reset are not strobes
  always @(negedge WR_N) in_wr = 1'b1;
  always @(posedge WR_N) begin
    if (in_wr) begin
      in_wr = 1'b0;
      c = chip(CS_N);
      wcnt[c]++;
      if (!A0 && D_O[4]) begin
        icw[c][0] = D_O;
        step[c] = 1;
      end else if (!A0) begin
        last_cmd[c] = D_O;
        if (D_O[6]) isb[c][D_O[2:0]] = 1'b0;
        else if (D_O[5]) isb[c] = isb[c] & (isb[c] - 8'h01);
      end else if (step[c] == 1) begin
        icw[c][1] = D_O;
        step[c] = icw[c][0][1] ? 0 : 2;
      end else if (step[c] == 2) begin
        icw[c][2] = D_O;
        step[c] = 0;
      end else mask[c] = D_O;
    end
  end
  always @(negedge RD_N) D_I = mask[chip(CS_N)];
  always @(negedge ACK_N) begin
    in_ack = 1'b1;
    s = slave(CAS_I);
    D_I = (ackn == 0) ? 8'hCD : (ackn == 1) ? (icw[s][0] & 8'hE0) : icw[s][1];
  end
  // Released bus shows the inverse of the last byte
  always @(posedge RD_N or posedge ACK_N) D_I = ~D_I;
  always @(posedge ACK_N) begin
    if (in_ack) begin
      in_ack = 1'b0;
      ackn = (ackn + 1) % 3;
      if (ackn == 1) begin
        CAS_I = REQ[2:0];
        isb[0][REQ[2:0]] = 1'b1;
      end
      if (ackn == 0) CAS_I = 3'h0;
    end
  end
endmodule : pic_cascade_model

// *** pic_host_defs.svh ***
// Constants for the cascaded interrupt controller host
`ifndef PIC_HOST_DEFS_SVH
`define PIC_HOST_DEFS_SVH
`define CLK_PERIOD_NS 10
`define T_STROBE_NS 300
`define T_A0_HOLD_NS 220
`define T_FLOAT_NS 120
`define T_CAS_STABLE_NS 500
`define CYC_MIN(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_CYC 2
`define STROBE_CYC (`CYC_MIN(`T_STROBE_NS) + `SYNC_CYC)
`define HOLD_CYC `CYC_MIN(`T_A0_HOLD_NS)
`define ACK_GAP_CYC `CYC_MIN(`T_CAS_STABLE_NS)
`define FLOAT_CYC `CYC_MIN(`T_FLOAT_NS)
`define PORT_EVEN 1'h0
`define PORT_ODD 1'h1
`define INIT_CONTROL_FIRST_MARK 2'h2
`define END_SERVICE_COMMAND_EOI 8'h20
`define END_SERVICE_COMMAND_ROT_EOI 8'hA0
`define END_SERVICE_COMMAND_TARGETED_END_OF_SERVICE 5'h0C
`define END_SERVICE_COMMAND_ROT_TARGETED_END_OF_SERVICE 5'h1C
`define SLAVE_ID_PAD 5'h00
`define MASTER_SEL 4'h0
`define MAX_SEL 4'h8
`define ROLE_PINS 9'h001
`endif

// *** pic_host_pkg.sv ***
// Types for the cascaded interrupt controller host
package pic_host_pkg;
  typedef enum logic [3:0] {OP_INIT, OP_MASK_WR, OP_MASK_RD, OP_EOI, OP_EOI_CASC,
    OP_ROT_EOI, OP_TARGETED_END_OF_SERVICE, OP_ROT_TARGETED_END_OF_SERVICE, OP_ACK} op_e;
  typedef enum logic [1:0] {K_WR, K_RD, K_ACK} kind_e;
  typedef enum logic [2:0] {PH_IDLE, PH_SETUP, PH_PULSE, PH_HOLD, PH_GAP} phase_e;
  typedef struct packed {
    op_e op;
    logic [3:0] sel;
    logic [2:0] level;
    logic [7:0] data;
    logic [15:0] vector;
    logic interval4;
    logic single;
    logic [7:0] cascade_cfg;
  } cmd_s;
  typedef struct packed {
    kind_e kind;
    logic a0;
    logic [3:0] sel;
    logic [7:0] data;
  } step_s;
  typedef struct packed {
    phase_e phase;
    cmd_s cmd;
    logic [1:0] idx;
    logic [5:0] cnt;
    logic [8:0] cs_n;
    logic rd_n;
    logic wr_n;
    logic ack_n;
    logic a0;
    logic [7:0] dout;
    logic doe;
    logic [7:0] din_s1;
    logic [7:0] din_s2;
    logic [2:0] cas_s1;
    logic [2:0] cas_s2;
    logic int_s1;
    logic int_s2;
    logic [23:0] rsp;
    logic [2:0] cas_code;
    logic rsp_valid;
    logic rsp_err;
    logic ready;
    logic [8:0] role;
  } state_s;
endpackage : pic_host_pkg
